/* File: hdl/rsxe_exec.sv */
/*
 Execution unit for rotate-left, sleep, subtracts, nibble swap,
 direction load and exclusive-OR. The core presents one decoded
 operation per cycle with the file register value already read; this
 block writes the accumulator, direction registers and flags, and
 returns file write-back as a one-cycle strobe. Ops that arrive while
 asleep are dropped, since the core clock is stopped then.
*/
// What this block does
// RL1: rotate file left through carry, carry only
// RL2: old carry in bit0, bit7 out
// RL3: sleep clears power-down, sets expiry, clears watchdog
// RL4: sleep then halts with oscillator stopped
// RL5: literal minus accumulator into accumulator
// RL6: subtract carry/digit carry mean no borrow
// RL7: file minus accumulator to chosen destination
// RL8: file minus accumulator minus borrow, flags
// RL9: swap file nibbles, flags untouched
// RL10: destination bit 0 accumulator, 1 file
// RL11: accumulator to direction A, B, C
// RL12: literal xor accumulator, zero flag only
// RL13: file xor accumulator, zero flag only
// RL14: zero flag set when result is zero
`timescale 1ns/1ns
`default_nettype none
module rsxe_exec #(
    parameter int W  = 8,
    parameter int AW = 7
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                nrst_i,
    // Decoded instruction
    input  wire logic                op_valid_i,
    input  wire rsxe_pkg::rsxe_op_t  op_i,
    input  wire logic [AW-1:0]       file_addr_i,
    input  wire logic                dest_i,
    input  wire logic [W-1:0]        literal_i,
    input  wire logic [2:0]          dir_sel_i,
    input  wire logic [W-1:0]        file_rdata_i,
    // Wake from sleep
    input  wire logic                wake_i,
    // File write-back
    output logic                     file_we_o,
    output logic [AW-1:0]            file_waddr_o,
    output logic [W-1:0]             file_wdata_o,
    // Core state
    output logic [W-1:0]             acc_o,
    output logic                     carry_flag_o,
    output logic                     digit_carry_flag_o,
    output logic                     zero_flag_o,
    output logic                     watchdog_expiry_flag_o,
    output logic                     power_down_flag_o,
    output logic                     watchdog_clear_o,
    output logic                     sleep_o,
    output logic                     osc_run_o,
    // Port direction registers
    output logic [W-1:0]             port_a_direction_o,
    output logic [W-1:0]             port_b_direction_o,
    output logic [W-1:0]             port_c_direction_o
);
    logic       rst_sync1_reg;
    logic       rst_sync2_reg;
    logic       rst_n;
    logic [W-1:0] sub_a;
    logic [W-1:0] sub_diff;
    logic       sub_carry;
    logic       sub_dc;
    logic       sub_borrow;
    logic [W-1:0] result;
    logic       to_file;
    logic       writes_dest;
    logic       sets_z;
    logic       sets_cdc;
    logic       sets_c_rot;
    logic       go;
    logic [W-1:0] acc_reg;
    logic       c_reg;
    logic       dc_reg;
    logic       z_reg;
    logic       expiry_reg;
    logic       pdown_reg;
    logic       wdt_clr_reg;
    logic       sleep_reg;
    logic       osc_run_reg;
    logic       we_reg;
    logic [AW-1:0] waddr_reg;
    logic [W-1:0]  wdata_reg;
    logic [W-1:0]  dir_a_reg;
    logic [W-1:0]  dir_b_reg;
    logic [W-1:0]  dir_c_reg;

    // Reset release through two flops so all state leaves reset together
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end
    assign rst_n = rst_sync2_reg;

    // Instructions are ignored while asleep; the core's clock is stopped
    assign go = op_valid_i && !sleep_reg;

    // Literal form uses k as minuend, others the file value
    assign sub_a      = (op_i == rsxe_pkg::RSXE_OP_LITERAL_MINUS_ACC)
                      ? literal_i : file_rdata_i;
    // Plain subtracts have no borrow; the borrow form uses inverted carry
    assign sub_borrow = (op_i == rsxe_pkg::RSXE_OP_REG_MINUS_ACC_BORROW)
                      ? !c_reg : 1'b0;                           // [RL8]

    rsxe_sub8 #(
        .W             (W)
    ) u_sub (
        .a_i           (sub_a),
        .b_i           (acc_reg),
        .borrow_i      (sub_borrow),
        .diff_o        (sub_diff),
        .carry_o       (sub_carry),
        .digit_carry_o (sub_dc)
    );

    always_comb begin
        result      = acc_reg;
        writes_dest = 1'b0;
        to_file     = 1'b0;
        sets_z      = 1'b0;
        sets_cdc    = 1'b0;
        sets_c_rot  = 1'b0;
        unique case (op_i)
            rsxe_pkg::RSXE_OP_ROTATE_LEFT_CARRY: begin
                result      = {file_rdata_i[W-2:0], c_reg};       // [RL1] [RL2]
                writes_dest = 1'b1;
                to_file     = dest_i;
                sets_c_rot  = 1'b1;
            end
            // Literal form has no file operand, so dest_i is ignored
            rsxe_pkg::RSXE_OP_LITERAL_MINUS_ACC: begin
                result      = sub_diff;                           // [RL5]
                writes_dest = 1'b1;
                sets_z      = 1'b1;
                sets_cdc    = 1'b1;
            end
            rsxe_pkg::RSXE_OP_REG_MINUS_ACC,
            rsxe_pkg::RSXE_OP_REG_MINUS_ACC_BORROW: begin
                result      = sub_diff;                           // [RL7] [RL8]
                writes_dest = 1'b1;
                to_file     = dest_i;
                sets_z      = 1'b1;
                sets_cdc    = 1'b1;
            end
            rsxe_pkg::RSXE_OP_NIBBLE_EXCHANGE: begin
                result      = {file_rdata_i[3:0], file_rdata_i[7:4]}; // [RL9]
                writes_dest = 1'b1;
                to_file     = dest_i;
            end
            rsxe_pkg::RSXE_OP_XOR_LITERAL_ACC: begin
                result      = acc_reg ^ literal_i;                // [RL12]
                writes_dest = 1'b1;
                sets_z      = 1'b1;
            end
            rsxe_pkg::RSXE_OP_XOR_REG_ACC: begin
                result      = acc_reg ^ file_rdata_i;             // [RL13]
                writes_dest = 1'b1;
                to_file     = dest_i;
                sets_z      = 1'b1;
            end
            default: begin
                result      = acc_reg;
            end
        endcase
    end

    // Accumulator update
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= rsxe_pkg::RSXE_ACC_RST;
        end else if (go && writes_dest
                     && (to_file == rsxe_pkg::RSXE_DEST_ACC)) begin
            acc_reg <= result;                                    // [RL10]
        end
    end

    // File write-back strobe, one cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            we_reg    <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
        end else begin
            we_reg <= go && writes_dest
                      && (to_file == rsxe_pkg::RSXE_DEST_FILE);   // [RL10]
            if (go && writes_dest) begin
                waddr_reg <= file_addr_i;
                wdata_reg <= result;
            end
        end
    end

    // Carry: rotate and subtracts only
    // Swap, xor and direction load keep it, so borrow chains survive them
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            c_reg <= 1'b0;
        end else if (go && sets_c_rot) begin
            c_reg <= file_rdata_i[W-1];                           // [RL2]
        end else if (go && sets_cdc) begin
            c_reg <= sub_carry;                                   // [RL6]
        end
    end

    // Digit carry: subtracts only
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dc_reg <= 1'b0;
        end else if (go && sets_cdc) begin
            dc_reg <= sub_dc;                                     // [RL6]
        end
    end

    // Zero flag
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            z_reg <= 1'b0;
        end else if (go && sets_z) begin
            z_reg <= (result == '0);                              // [RL14]
        end
    end

    // Power status bits, changed only by sleep here
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            expiry_reg <= rsxe_pkg::RSXE_EXPIRY_RST;
            pdown_reg  <= rsxe_pkg::RSXE_PDOWN_RST;
        end else if (go && op_i == rsxe_pkg::RSXE_OP_SLEEP) begin
            pdown_reg  <= 1'b0;                                   // [RL3]
            expiry_reg <= 1'b1;                                   // [RL3]
        end
    end

    // Watchdog clear pulse, one cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wdt_clr_reg <= 1'b0;
        end else begin
            wdt_clr_reg <= go && op_i == rsxe_pkg::RSXE_OP_SLEEP;   // [RL3]
        end
    end

    // Sleep state; the oscillator flag is its own flop so the pin sees
    // no gate between register and output
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sleep_reg   <= 1'b0;
            osc_run_reg <= 1'b1;
        end else if (go && op_i == rsxe_pkg::RSXE_OP_SLEEP) begin
            sleep_reg   <= 1'b1;                                  // [RL4]
            osc_run_reg <= 1'b0;                                  // [RL4]
        end else if (sleep_reg && wake_i) begin
            // Leaving sleep needs only the wake level; no op is consumed
            sleep_reg   <= 1'b0;
            osc_run_reg <= 1'b1;
        end
    end

    // Direction registers; other selectors are ignored
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dir_a_reg <= rsxe_pkg::RSXE_DIR_RST;
            dir_b_reg <= rsxe_pkg::RSXE_DIR_RST;
            dir_c_reg <= rsxe_pkg::RSXE_DIR_RST;
        end else if (go && op_i == rsxe_pkg::RSXE_OP_DIRECTION_LOAD) begin
            if (dir_sel_i == rsxe_pkg::RSXE_DIR_PORT_A) begin
                dir_a_reg <= acc_reg;                             // [RL11]
            end
            if (dir_sel_i == rsxe_pkg::RSXE_DIR_PORT_B) begin
                dir_b_reg <= acc_reg;                             // [RL11]
            end
            if (dir_sel_i == rsxe_pkg::RSXE_DIR_PORT_C) begin
                dir_c_reg <= acc_reg;                             // [RL11]
            end
        end
    end

    assign file_we_o              = we_reg;
    assign file_waddr_o           = waddr_reg;
    assign file_wdata_o           = wdata_reg;
    assign acc_o                  = acc_reg;
    assign carry_flag_o           = c_reg;
    assign digit_carry_flag_o     = dc_reg;
    assign zero_flag_o            = z_reg;
    assign watchdog_expiry_flag_o = expiry_reg;
    assign power_down_flag_o      = pdown_reg;
    assign watchdog_clear_o       = wdt_clr_reg;
    assign sleep_o                = sleep_reg;
    // Oscillator stops at the same edge that enters sleep
    assign osc_run_o              = osc_run_reg;                  // [RL4]
    assign port_a_direction_o     = dir_a_reg;
    assign port_b_direction_o     = dir_b_reg;
    assign port_c_direction_o     = dir_c_reg;
endmodule : rsxe_exec
`default_nettype wire

/* File: hdl/rsxe_pkg.sv */
/*
 Package for the rotate/subtract/xor execution group: operation codes,
 operand ranges, port direction selectors and reset values.
 Assumes a single 100 MHz clock domain in the enclosing core.
*/
`default_nettype none
package rsxe_pkg;
    typedef enum logic [3:0] {
        RSXE_OP_NONE,
        RSXE_OP_ROTATE_LEFT_CARRY,
        RSXE_OP_SLEEP,
        RSXE_OP_LITERAL_MINUS_ACC,
        RSXE_OP_REG_MINUS_ACC,
        RSXE_OP_REG_MINUS_ACC_BORROW,
        RSXE_OP_NIBBLE_EXCHANGE,
        RSXE_OP_DIRECTION_LOAD,
        RSXE_OP_XOR_LITERAL_ACC,
        RSXE_OP_XOR_REG_ACC
    } rsxe_op_t;

    localparam int          RSXE_DATA_W      = 8;
    localparam int          RSXE_ADDR_W      = 7;
    localparam logic [6:0]  RSXE_ADDR_MAX    = 7'h7F;
    localparam logic [2:0]  RSXE_DIR_PORT_A  = 3'h5;
    localparam logic [2:0]  RSXE_DIR_PORT_B  = 3'h6;
    localparam logic [2:0]  RSXE_DIR_PORT_C  = 3'h7;
    localparam logic        RSXE_DEST_ACC    = 1'h0;
    localparam logic        RSXE_DEST_FILE   = 1'h1;
    localparam logic [7:0]  RSXE_ACC_RST     = 8'h00;
    localparam logic [7:0]  RSXE_DIR_RST     = 8'hFF;
    localparam logic [7:0]  RSXE_WDT_CLEAR   = 8'h00;
    localparam logic        RSXE_EXPIRY_RST  = 1'h1;
    localparam logic        RSXE_PDOWN_RST   = 1'h1;
    localparam int          RSXE_EXEC_CYCLES = 1;
endpackage : rsxe_pkg
`default_nettype wire

/* File: hdl/rsxe_sub8.sv */
/*
 Eight-bit subtractor a - b - borrow giving result, carry and digit carry.
 Carry is the inverse of borrow, as the core's status convention expects.
*/
`timescale 1ns/1ns
`default_nettype none
module rsxe_sub8 #(
    parameter int W = 8
) (
    // Operands
    input  wire logic [W-1:0] a_i,
    input  wire logic [W-1:0] b_i,
    input  wire logic         borrow_i,
    // Results
    output logic      [W-1:0] diff_o,
    output logic              carry_o,
    output logic              digit_carry_o
);
    logic [W:0] full;
    logic [4:0] low;

    // Adding the one's complement keeps carry set when b + borrow <= a
    assign full          = {1'b0, a_i} + {1'b0, ~b_i} + {{W{1'b0}}, ~borrow_i};
    assign low           = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]}
                         + {4'h0, ~borrow_i};
    assign diff_o        = full[W-1:0];
    assign carry_o       = full[W];
    assign digit_carry_o = low[4];
endmodule : rsxe_sub8
`default_nettype wire

/* File: bench/rsxe_exec_asserts.sv */
/*
 Checker for rsxe_exec: result and flag relations of each operation except the borrow subtract and file xor.
 Assumes one clock and no request before the reset release settles.
*/
`timescale 1ns/1ns
`default_nettype none
module rsxe_exec_asserts #(
    parameter int W  = 8,
    parameter int AW = 7
) (
    // Clock, reset and request
    input wire logic               clk_i,
    input wire logic               nrst_i,
    input wire logic               op_valid_i,
    input wire rsxe_pkg::rsxe_op_t op_i,
    input wire logic [AW-1:0]      file_addr_i,
    input wire logic               dest_i,
    input wire logic [W-1:0]       literal_i,
    input wire logic [2:0]         dir_sel_i,
    input wire logic [W-1:0]       file_rdata_i,
    input wire logic               wake_i,
    // Results
    input wire logic               file_we_o,
    input wire logic [AW-1:0]      file_waddr_o,
    input wire logic [W-1:0]       file_wdata_o,
    input wire logic [W-1:0]       acc_o,
    input wire logic               carry_flag_o,
    input wire logic               digit_carry_flag_o,
    input wire logic               zero_flag_o,
    input wire logic               watchdog_expiry_flag_o,
    input wire logic               power_down_flag_o,
    input wire logic               watchdog_clear_o,
    input wire logic               sleep_o,
    input wire logic               osc_run_o,
    input wire logic [W-1:0]       port_a_direction_o
);
    // Ops while asleep are dropped, so they do not count
    wire logic ex = op_valid_i && !sleep_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    rot_carry_a : assert property (
        ex && op_i == rsxe_pkg::RSXE_OP_ROTATE_LEFT_CARRY && !dest_i
        |=> acc_o == $past({file_rdata_i[6:0], carry_flag_o})
        && carry_flag_o == $past(file_rdata_i[7]) && $stable(zero_flag_o))
        else $error("rotate result or carry wrong");
    sleep_entry_a : assert property (
        ex && op_i == rsxe_pkg::RSXE_OP_SLEEP |=> !power_down_flag_o
        && watchdog_expiry_flag_o && watchdog_clear_o && sleep_o
        && !osc_run_o) else $error("sleep entry status wrong");
    sleep_hold_a : assert property (
        sleep_o && !wake_i |=> sleep_o && $stable(acc_o))
        else $error("state moved while asleep");
    lit_sub_a : assert property (
        ex && op_i == rsxe_pkg::RSXE_OP_LITERAL_MINUS_ACC
        |=> acc_o == $past(literal_i - acc_o) && zero_flag_o == (acc_o == 0)
        && carry_flag_o == $past(acc_o <= literal_i))
        else $error("literal subtract wrong");
    reg_sub_a : assert property (
        ex && op_i == rsxe_pkg::RSXE_OP_REG_MINUS_ACC && dest_i
        |=> file_we_o && file_wdata_o == $past(file_rdata_i - acc_o)
        && file_waddr_o == $past(file_addr_i) && $stable(acc_o))
        else $error("register subtract write-back wrong");
    swap_flags_a : assert property (
        ex && op_i == rsxe_pkg::RSXE_OP_NIBBLE_EXCHANGE |=> $stable(
        {carry_flag_o, digit_carry_flag_o, zero_flag_o}))
        else $error("swap changed a flag");
    dir_a_load_a : assert property (
        ex && op_i == rsxe_pkg::RSXE_OP_DIRECTION_LOAD && dir_sel_i == 3'h5
        |=> port_a_direction_o == $past(acc_o) && $stable(carry_flag_o))
        else $error("direction load wrong");
    xor_lit_a : assert property (
        ex && op_i == rsxe_pkg::RSXE_OP_XOR_LITERAL_ACC
        |=> acc_o == $past(acc_o ^ literal_i) && zero_flag_o == (acc_o == 0)
        && $stable(carry_flag_o)) else $error("literal xor wrong");

    sleep_c  : cover property (ex && op_i == rsxe_pkg::RSXE_OP_SLEEP);
    wake_c   : cover property (sleep_o && wake_i);
    borrow_c : cover property (ex && !carry_flag_o
        && op_i == rsxe_pkg::RSXE_OP_REG_MINUS_ACC_BORROW);
endmodule : rsxe_exec_asserts

bind rsxe_exec rsxe_exec_asserts #(.W(W), .AW(AW)) u_chk (.clk_i, .nrst_i,
    .op_valid_i, .op_i, .file_addr_i, .dest_i, .literal_i, .dir_sel_i,
    .file_rdata_i, .wake_i, .file_we_o, .file_waddr_o, .file_wdata_o, .acc_o,
    .carry_flag_o, .digit_carry_flag_o, .zero_flag_o, .watchdog_expiry_flag_o,
    .power_down_flag_o, .watchdog_clear_o, .sleep_o, .osc_run_o,
    .port_a_direction_o);
`default_nettype wire

/* File: bench/rsxe_exec_tb.sv */
/*
 Testbench for rsxe_exec: a table of back-to-back ops, then direction,
 sleep/wake and reset cases. Assumes the core forwards file write-back.
*/
`timescale 1ns/1ns
`default_nettype none
module rsxe_exec_tb;
    logic               clk_i        = 1'b0;
    logic               nrst_i       = 1'b0;
    logic               op_valid_i   = 1'b0;
    rsxe_pkg::rsxe_op_t op_i         = rsxe_pkg::RSXE_OP_NONE;
    logic [6:0]         file_addr_i  = 7'h7F;
    logic               dest_i       = 1'b0;
    logic [7:0]         literal_i    = 8'h00;
    logic [2:0]         dir_sel_i    = 3'h0;
    logic [7:0]         file_rdata_i = 8'h00;
    logic               wake_i       = 1'b0;
    logic               file_we_o, carry_flag_o, digit_carry_flag_o;
    logic               zero_flag_o, watchdog_expiry_flag_o, sleep_o;
    logic               power_down_flag_o, watchdog_clear_o, osc_run_o;
    logic [6:0]         file_waddr_o;
    logic [7:0]         file_wdata_o, acc_o, port_a_direction_o;
    logic [7:0]         port_b_direction_o, port_c_direction_o;
    logic [47:0]        r;
    int                 error_cnt       = 0;
    int                 samples_checked = 0;
    // Row: op, dest, literal, file value, selector | acc, C DC Z we, wdata
    // Rows chain from the reset state, so their order matters
    logic [47:0] rows [24] = '{
        48'h3_1_37_00_0_37_C_00, 48'h3_0_37_00_0_00_E_00,
        48'h8_0_A5_00_0_A5_C_00, 48'h4_1_00_A4_0_A5_1_FF,
        48'h5_0_00_A6_0_00_E_00, 48'h1_0_00_E6_0_CD_E_00,
        48'h3_0_0C_00_0_3F_0_00, 48'h1_1_00_66_0_3F_1_CC,
        48'h1_0_00_80_0_00_8_00, 48'h6_0_00_3C_0_C3_8_00,
        48'h6_1_00_12_0_C3_9_21, 48'h9_1_00_C3_0_C3_B_00,
        48'h9_0_00_0F_0_CC_8_00, 48'h5_1_00_CC_0_CC_F_00,
        48'h4_0_00_00_0_34_0_00, 48'h5_0_00_35_0_00_E_00,
        48'h3_0_90_00_0_90_C_00, 48'h7_0_00_00_5_90_C_00,
        48'h8_0_3C_00_0_AC_C_00, 48'h7_0_00_00_6_AC_C_00,
        48'h8_0_F0_00_0_5C_C_00, 48'h7_0_00_00_7_5C_C_00,
        48'h7_0_00_00_4_5C_C_00, 48'h0_0_00_00_0_5C_C_00};

    rsxe_exec uut (.clk_i, .nrst_i, .op_valid_i, .op_i, .file_addr_i,
        .dest_i, .literal_i, .dir_sel_i, .file_rdata_i, .wake_i, .file_we_o,
        .file_waddr_o, .file_wdata_o, .acc_o, .carry_flag_o,
        .digit_carry_flag_o, .zero_flag_o, .watchdog_expiry_flag_o,
        .power_down_flag_o, .watchdog_clear_o, .sleep_o, .osc_run_o,
        .port_a_direction_o, .port_b_direction_o, .port_c_direction_o);

    always #5 clk_i = ~clk_i;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // Whole run is some forty cycles; this leaves ample margin
    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (4) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check({4'h0, power_down_flag_o, watchdog_expiry_flag_o, sleep_o,
            osc_run_o}, 8'h0D);
        check(port_a_direction_o, rsxe_pkg::RSXE_DIR_RST);
        for (int i = 0; i < 24; i++) begin
            r = rows[i];
            op_valid_i = 1'b1;
            op_i = rsxe_pkg::rsxe_op_t'(r[47:44]);
            dest_i = r[40];
            literal_i = r[39:32];
            file_rdata_i = r[31:24];
            dir_sel_i = r[22:20];
            file_addr_i = 7'(127 - i);
            @(negedge clk_i);
            check(acc_o, r[19:12]);
            check({4'h0, carry_flag_o, digit_carry_flag_o, zero_flag_o,
                file_we_o}, {4'h0, r[11:8]});
            if (r[8]) begin
                check(file_wdata_o, r[7:0]);
                check({1'b0, file_waddr_o}, {1'b0, 7'(127 - i)});
            end
        end
        check(port_a_direction_o, 8'h90);
        check(port_b_direction_o, 8'hAC);
        check(port_c_direction_o, 8'h5C);
        op_i = rsxe_pkg::RSXE_OP_SLEEP;
        @(negedge clk_i);
        op_i = rsxe_pkg::RSXE_OP_XOR_LITERAL_ACC;
        literal_i = 8'hFF;
        check({4'h0, power_down_flag_o, watchdog_expiry_flag_o,
            watchdog_clear_o, sleep_o}, 8'h07);
        check({7'h00, osc_run_o}, 8'h00);
        @(negedge clk_i);
        check({7'h00, watchdog_clear_o}, 8'h00);
        check(acc_o, 8'h5C);
        wake_i = 1'b1;
        op_valid_i = 1'b0;
        @(negedge clk_i);
        wake_i = 1'b0;
        check({6'h00, sleep_o, osc_run_o}, 8'h01);
        // Reset in mid-run must restore the status bits at once
        nrst_i = 1'b0;
        #1;
        check({6'h00, power_down_flag_o, watchdog_expiry_flag_o},
            8'h03);
        check(port_a_direction_o, 8'hFF);
        // Second release: first op only after the two-flop release is done
        @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check({7'h00, power_down_flag_o}, 8'h01);
        op_valid_i = 1'b1;
        op_i = rsxe_pkg::RSXE_OP_XOR_LITERAL_ACC;
        literal_i = 8'h00;
        @(negedge clk_i);
        check(acc_o, 8'h00);
        check({7'h00, zero_flag_o}, 8'h01);
        give_verdict();
    end
endmodule : rsxe_exec_tb
`default_nettype wire
